/* File: rtl/vtcp_fifo.sv */
// Small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module vtcp_fifo #(
   parameter int unsigned WIDTH = 27,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Fill side
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   // Drain side
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wptr;
      logic [AW-1:0]               rptr;
      logic [AW:0]                 count;
   } vtcp_fifo_state_t;

   vtcp_fifo_state_t r_reg;
   vtcp_fifo_state_t r_next;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least 2");
   end

   assign in_ready_out  = (r_reg.count != (AW+1)'(DEPTH));
   assign out_valid_out = (r_reg.count != '0);
   assign out_data_out  = r_reg.mem[r_reg.rptr];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wptr] = in_data_in;
         r_next.wptr = r_reg.wptr + 1'b1;
      end
      if (pop) begin
         r_next.rptr = r_reg.rptr + 1'b1;
      end
      r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

/* File: rtl/vtcp_map.svh */
// Register map, field positions, reset values and timing figures of the channel path
`ifndef VTCP_MAP_SVH
`define VTCP_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define VTCP_ADDR_FLAGS0      16'hE502
`define VTCP_ADDR_ENABLE0     16'hE50A
`define VTCP_ADDR_SETUP       16'hE618
`define VTCP_ADDR_CHSEL       16'hE708
`define VTCP_ADDR_TGAIN_BASE  16'h4380
`define VTCP_ADDR_VGAIN_BASE  16'h4388
`define VTCP_ADDR_TOFF_BASE   16'hE710
`define VTCP_ADDR_TRES_BASE   16'hE520
`define VTCP_ADDR_WAVE_BASE   16'hE530

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define VTCP_BIT_READY        17
`define VTCP_BIT_HPF          4
`define VTCP_ROUTE_A_LSB      8
`define VTCP_ROUTE_B_LSB      10
`define VTCP_ROUTE_C_LSB      12
`define VTCP_SETUP_RESET      16'h0010
`define VTCP_CHSEL_RESET      8'h0F
`define VTCP_OFFSET_SHIFT     11
`define VTCP_GAIN_FRAC        23
`define VTCP_HPF_SHIFT        8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VTCP_CLK_KHZ          20000
`define VTCP_TEMP_SETTLE_MS   1024
`define VTCP_PIN_DELAY_NS     70
`define VTCP_PIN_LOW_US       10

`endif

/* File: rtl/vtcp_pkg.sv */
// Types shared by the voltage and temperature channel path
package vtcp_pkg;
`include "vtcp_map.svh"

   typedef struct packed {
      logic                  flag_ready;
      logic [31:0]           enable0;
      logic [15:0]           setup;
      logic [7:0]            chsel;
      logic [3:0][7:0]       toff;
      logic [3:0][23:0]      tgain;
      logic [7:0][23:0]      vgain;
      logic [3:0][23:0]      tres;
      logic [7:0][23:0]      wave;
      logic [7:0][31:0]      dc;
      logic [2:0][23:0]      route;
      logic [3:0][24:0]      ttimer;
      logic [3:0]            tready;
      logic                  capture_pend;
      logic [7:0]            pin_cnt;
      logic                  pin_n;
      logic                  streaming;
      logic [2:0]            stream_idx;
      logic [31:0]           rdata;
   } vtcp_state_t;

endpackage

/* File: rtl/vtcp_top.sv */
// Voltage and temperature channel path: select, trims, filtering, samples, routing
//
// Overview of operation
// - Select bits reset to 1; a set bit drives select high, second voltage measured.
// - A cleared select bit drives select low; third-ADC data is temperature.
// - Factory temperature offset fetched over the link into read-only 8-bit registers.
// - Stored offset is shifted left eleven bits before adding to temperature.
// - Temperature scaled by one plus signed gain over two to the 23rd.
// - Temperature result first loaded 1.024 s after select low, then every sample.
// - No temperature result loaded unless select stayed low for 1.024 s.
// - Temperature result reads back as 32 bits with upper eight bits zero.
// - Each of eight voltage paths scaled by one plus its own signed gain.
// - Voltage gain acts ahead of routing, waveform samples and all derived results.
// - Voltage gain reads back sign-extended to 28 bits plus four zero bits.
// - Setup bit 4, reset 1, enables all high-pass filters; clear bypasses them.
// - Waveform samples captured at the filter output into 24-bit registers each sample; second-voltage ones only while select high.
// - Status bit 17 sets on new samples; interrupt only when mask bit 17 set.
// - Pin function 00: pin low about 70 ns after flag set, for 10 us.
// - Waveform sample reads back sign-extended to 32 bits.
// - Any phase voltage can feed another phase's power datapath.
// - Bits 9:8 pick phase A datapath voltage: 01 B, 10 C, else A.
// - Bits 11:10 pick phase B datapath voltage: 01 C, 10 A, else B.
// - Bits 13:12 pick phase C datapath voltage: 01 A, 10 B, else C.
// - Writing 1 to status bit 17 clears the flag and releases the interrupt.
`timescale 1ns/1ps
module vtcp_top import vtcp_pkg::*; #(
   parameter int unsigned TEMP_SETTLE_CYC = `VTCP_TEMP_SETTLE_MS * `VTCP_CLK_KHZ,
   parameter int unsigned FIFO_DEPTH      = 4
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Register access port
   input  wire logic             reg_wr_in,
   input  wire logic             reg_rd_in,
   input  wire logic [15:0]      reg_addr_in,
   input  wire logic [31:0]      reg_wdata_in,
   output logic [31:0]           reg_rdata_out,
   // Front-end sample inputs
   input  wire logic             sample_strobe_in,
   input  wire logic [3:0][23:0] volt_adc_in,
   input  wire logic [3:0][23:0] third_adc_in,
   input  wire logic [3:0]       offset_load_in,
   input  wire logic [3:0][7:0]  offset_value_in,
   // Front-end select outputs
   output logic                  select_out_a,
   output logic                  select_out_b,
   output logic                  select_out_c,
   output logic                  select_out_n,
   // Voltages routed to the phase power datapaths
   output logic [23:0]           route_volt_to_a_out,
   output logic [23:0]           route_volt_to_b_out,
   output logic [23:0]           route_volt_to_c_out,
   // Waveform sample stream
   output logic [26:0]           wave_data_out,
   output logic                  wave_valid_out,
   input  wire logic             wave_ready_in,
   // Event outputs
   output logic                  interrupt_0_n_out,
   output logic                  shared_event_pin_out
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int unsigned PIN_DELAY_CYC =
      (`VTCP_PIN_DELAY_NS * `VTCP_CLK_KHZ + 999999) / 1000000;
   localparam int unsigned PIN_LOW_CYC = `VTCP_PIN_LOW_US * `VTCP_CLK_KHZ / 1000;
   localparam logic [7:0]  PIN_TOTAL   = 8'(PIN_DELAY_CYC + PIN_LOW_CYC);
   localparam logic [7:0]  PIN_LOW     = 8'(PIN_LOW_CYC);
   localparam logic [24:0] TEMP_LAST   = 25'(TEMP_SETTLE_CYC - 1);

   if (TEMP_SETTLE_CYC < 1 || TEMP_SETTLE_CYC > 33554432) begin : g_bad_settle
      $error("TEMP_SETTLE_CYC must fit the 25-bit settle timer");
   end
   if (PIN_DELAY_CYC + PIN_LOW_CYC > 255) begin : g_bad_pin
      $error("Pin pulse does not fit the 8-bit pulse counter");
   end

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   function automatic logic signed [23:0] sat24(input logic signed [25:0] v);
      if (v > 26'sh07FFFFF) begin
         return 24'sh7FFFFF;
      end else if (v < 26'sh3800000) begin
         return 24'sh800000;
      end
      return v[23:0];
   endfunction

   function automatic logic signed [23:0] apply_gain(input logic signed [23:0] x,
                                                      input logic signed [23:0] g);
      logic signed [47:0] p;
      p = x * g;
      return sat24(26'(x) + 26'(p >>> `VTCP_GAIN_FRAC));
   endfunction

   vtcp_state_t              r_reg;
   vtcp_state_t              r_next;
   logic signed [7:0][23:0]  volt_scaled;
   logic signed [7:0][23:0]  volt_hpf;
   logic        [7:0][31:0]  dc_step;
   logic signed [3:0][23:0]  temp_scaled;
   logic        [2:0][1:0]   route_field;
   logic                     fifo_ready;
   logic                     highpass_on;

   assign highpass_on = r_reg.setup[`VTCP_BIT_HPF];
   assign route_field[0] = r_reg.setup[`VTCP_ROUTE_A_LSB +: 2];
   assign route_field[1] = r_reg.setup[`VTCP_ROUTE_B_LSB +: 2];
   assign route_field[2] = r_reg.setup[`VTCP_ROUTE_C_LSB +: 2];

   // ----------------------------------------------------------------
   // Per-path datapaths
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 8; k++) begin : g_volt
      logic signed [23:0] raw;
      logic signed [33:0] diff;
      assign raw = (k < 4) ? volt_adc_in[k % 4] : third_adc_in[k % 4];
      // gain per path, ahead of filter and routing
      assign volt_scaled[k] = apply_gain(raw, r_reg.vgain[k]);
      // filter or bypass
      // Element selects are unsigned, so sign is restored before widening
      assign volt_hpf[k] = highpass_on ?
         sat24(26'($signed(volt_scaled[k])) - 26'($signed(r_reg.dc[k][31:8]))) : volt_scaled[k];
      assign diff = (34'($signed(volt_scaled[k])) <<< 8) - 34'($signed(r_reg.dc[k]));
      assign dc_step[k] = r_reg.dc[k] + 32'(diff >>> `VTCP_HPF_SHIFT);
   end

   for (genvar p = 0; p < 4; p++) begin : g_temp
      logic signed [23:0] with_offset;
      assign with_offset = sat24(26'($signed(third_adc_in[p]))
         + (26'($signed(r_reg.toff[p])) <<< `VTCP_OFFSET_SHIFT));
      assign temp_scaled[p] = apply_gain(with_offset, r_reg.tgain[p]);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] rd_word;
      logic        clr_ready;
      logic [1:0]  f;
      rd_word   = 32'h0000_0000;
      clr_ready = 1'b0;
      f         = 2'h0;
      r_next = r_reg;
      r_next.capture_pend = 1'b0;

      // Register writes
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `VTCP_ADDR_FLAGS0:  clr_ready = reg_wdata_in[`VTCP_BIT_READY];
            `VTCP_ADDR_ENABLE0: r_next.enable0 = reg_wdata_in;
            `VTCP_ADDR_SETUP:   r_next.setup = reg_wdata_in[15:0];
            `VTCP_ADDR_CHSEL:   r_next.chsel = reg_wdata_in[7:0];
            default: begin
               if (reg_addr_in[15:2] == `VTCP_ADDR_TGAIN_BASE >> 2) begin
                  r_next.tgain[reg_addr_in[1:0]] = reg_wdata_in[23:0];
               end
               if (reg_addr_in[15:3] == `VTCP_ADDR_VGAIN_BASE >> 3) begin
                  r_next.vgain[reg_addr_in[2:0]] = reg_wdata_in[23:0];
               end
            end
         endcase
      end

      for (int p = 0; p < 4; p++) begin
         if (offset_load_in[p]) begin
            r_next.toff[p] = offset_value_in[p];
         end
      end

      // settle timer restarts whenever select goes high
      for (int p = 0; p < 4; p++) begin
         if (r_reg.chsel[p]) begin
            r_next.ttimer[p] = '0;
            r_next.tready[p] = 1'b0;
         end else if (r_reg.ttimer[p] == TEMP_LAST) begin
            r_next.tready[p] = 1'b1;
         end else begin
            r_next.ttimer[p] = r_reg.ttimer[p] + 25'h0000001;
         end
      end

      // Stream drains the sample set into the buffer
      if (r_reg.streaming && fifo_ready) begin
         r_next.stream_idx = r_reg.stream_idx + 3'h1;
         r_next.streaming  = (r_reg.stream_idx != 3'h7);
      end

      if (sample_strobe_in) begin
         r_next.capture_pend = 1'b1;
         r_next.streaming    = 1'b1;
         r_next.stream_idx   = 3'h0;
         for (int k = 0; k < 8; k++) begin
            r_next.dc[k] = dc_step[k];
            // second-voltage sample held while temperature selected
            if (k < 4 || r_reg.chsel[k % 4]) begin
               r_next.wave[k] = volt_hpf[k];
            end
         end
         for (int p = 0; p < 3; p++) begin
            f = route_field[p];
            unique case (f)
               2'h1:    r_next.route[p] = volt_hpf[(p + 1) % 3];
               2'h2:    r_next.route[p] = volt_hpf[(p + 2) % 3];
               default: r_next.route[p] = volt_hpf[p];
            endcase
         end
         for (int p = 0; p < 4; p++) begin
            if (!r_reg.chsel[p] && r_reg.tready[p]) begin
               r_next.tres[p] = temp_scaled[p];
            end
         end
      end

      // flag: a new set wins over a clear
      r_next.flag_ready = (r_reg.flag_ready && !clr_ready) || r_reg.capture_pend;

      if (r_reg.capture_pend) begin
         r_next.pin_cnt = PIN_TOTAL;
      end else if (r_reg.pin_cnt != 8'h00) begin
         r_next.pin_cnt = r_reg.pin_cnt - 8'h01;
      end
      r_next.pin_n = !((r_reg.setup[1:0] == 2'h0) && (r_next.pin_cnt != 8'h00)
                       && (r_next.pin_cnt <= PIN_LOW));

      // Register reads
      unique case (reg_addr_in)
         `VTCP_ADDR_FLAGS0:  rd_word[`VTCP_BIT_READY] = r_reg.flag_ready;
         `VTCP_ADDR_ENABLE0: rd_word = r_reg.enable0;
         `VTCP_ADDR_SETUP:   rd_word = {16'h0000, r_reg.setup};
         `VTCP_ADDR_CHSEL:   rd_word = {24'h000000, r_reg.chsel};
         default: begin
            if (reg_addr_in[15:2] == `VTCP_ADDR_TGAIN_BASE >> 2) begin
               rd_word = {{4{r_reg.tgain[reg_addr_in[1:0]][23]}},
                          r_reg.tgain[reg_addr_in[1:0]], 4'h0};
            end
            if (reg_addr_in[15:3] == `VTCP_ADDR_VGAIN_BASE >> 3) begin
               rd_word = {{4{r_reg.vgain[reg_addr_in[2:0]][23]}},
                          r_reg.vgain[reg_addr_in[2:0]], 4'h0};
            end
            if (reg_addr_in[15:2] == `VTCP_ADDR_TOFF_BASE >> 2) begin
               rd_word = {24'h000000, r_reg.toff[reg_addr_in[1:0]]};
            end
            if (reg_addr_in[15:2] == `VTCP_ADDR_TRES_BASE >> 2) begin
               rd_word = {8'h00, r_reg.tres[reg_addr_in[1:0]]};
            end
            if (reg_addr_in[15:3] == `VTCP_ADDR_WAVE_BASE >> 3) begin
               rd_word = {{8{r_reg.wave[reg_addr_in[2:0]][23]}},
                          r_reg.wave[reg_addr_in[2:0]]};
            end
         end
      endcase
      if (reg_rd_in) begin
         r_next.rdata = rd_word;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r_reg <= '0;
         // select bits and filter enable reset to 1
         r_reg.chsel <= `VTCP_CHSEL_RESET;
         r_reg.setup <= `VTCP_SETUP_RESET;
         r_reg.pin_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Sample buffer
   // ----------------------------------------------------------------
   vtcp_fifo #(
      .WIDTH (27),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (r_reg.streaming),
      .in_data_in    ({r_reg.stream_idx, r_reg.wave[r_reg.stream_idx]}),
      .in_ready_out  (fifo_ready),
      .out_valid_out (wave_valid_out),
      .out_data_out  (wave_data_out),
      .out_ready_in  (wave_ready_in)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // select pins follow the select bits
   assign select_out_a = r_reg.chsel[0];
   assign select_out_b = r_reg.chsel[1];
   assign select_out_c = r_reg.chsel[2];
   assign select_out_n = r_reg.chsel[3];
   assign route_volt_to_a_out = r_reg.route[0];
   assign route_volt_to_b_out = r_reg.route[1];
   assign route_volt_to_c_out = r_reg.route[2];
   assign reg_rdata_out = r_reg.rdata;
   // interrupt gated by the mask bit
   assign interrupt_0_n_out = !(r_reg.flag_ready && r_reg.enable0[`VTCP_BIT_READY]);
   assign shared_event_pin_out = r_reg.pin_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SELECT_WRITE: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      reg_wr_in && reg_addr_in == `VTCP_ADDR_CHSEL
      |=> select_out_a == $past(reg_wdata_in[0]) && select_out_n == $past(reg_wdata_in[3]))
      else $error("select output does not follow select bit");
   AST_TEMP_SETTLED: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $changed(r_reg.tres[0]) |-> $past(r_reg.tready[0] && !r_reg.chsel[0]))
      else $error("temperature loaded before settle time");
   AST_READY_SET: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      sample_strobe_in |=> ##1 r_reg.flag_ready)
      else $error("sample-ready flag not set after capture");
   AST_IRQ_RELEASE: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      reg_wr_in && reg_addr_in == `VTCP_ADDR_FLAGS0 && reg_wdata_in[17]
      && !r_reg.capture_pend |=> interrupt_0_n_out && !r_reg.flag_ready)
      else $error("interrupt not released by write-one-clear");
   AST_PIN_PULSE: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $fell(shared_event_pin_out) |-> r_reg.setup[1:0] == 2'h0 ##1 !shared_event_pin_out [*8])
      else $error("event pin pulse wrong");
   AST_PIN_DELAY: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(r_reg.flag_ready) && r_reg.setup[1:0] == 2'h0 && !sample_strobe_in
      |-> shared_event_pin_out ##2 !shared_event_pin_out)
      else $error("event pin not lowered two cycles after flag");
   AST_TEMP_READ: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      reg_rd_in && reg_addr_in[15:2] == `VTCP_ADDR_TRES_BASE >> 2
      |=> reg_rdata_out[31:24] == 8'h00)
      else $error("temperature read not zero-padded");
   AST_GAIN_READ: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      reg_rd_in && reg_addr_in[15:3] == `VTCP_ADDR_VGAIN_BASE >> 3
      |=> reg_rdata_out[3:0] == 4'h0 && reg_rdata_out[31:27] == {5{reg_rdata_out[27]}})
      else $error("gain read format wrong");
   AST_WAVE_READ: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      reg_rd_in && reg_addr_in[15:3] == `VTCP_ADDR_WAVE_BASE >> 3
      |=> reg_rdata_out[31:24] == {8{reg_rdata_out[23]}})
      else $error("sample read not sign-extended");
   AST_ROUTE_A: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      sample_strobe_in && route_field[0] == 2'h1 |=> route_volt_to_a_out == r_reg.wave[1])
      else $error("phase A routing wrong");
endmodule

/* File: tb/vtcp_fe_model.sv */
// Front-end model: ADC words, temperature or second voltage by select, offset load
`timescale 1ns/1ps
module vtcp_fe_model (
   // Clock, reset and select lines
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic [3:0]  select_in,
   // Sample words and factory offsets
   output logic [3:0][23:0] volt_out,
   output logic [3:0][23:0] third_out,
   output logic [3:0]       offset_load_out,
   output logic [3:0][7:0]  offset_value_out
);
   logic sent_reg;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sent_reg <= 1'b0;
      end else begin
         sent_reg <= 1'b1;
      end
   end
   assign offset_load_out  = {4{resetn_in & ~sent_reg}};
   // Lines show the inverse once the load is over
   assign offset_value_out = offset_load_out[0] ? {4{8'hFF}} : {4{8'h00}};
   assign volt_out         = {24'hF00000, 24'h300000, 24'h200000, 24'h100000};
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         third_out[p] = select_in[p] ? 24'h0A0000 : 24'h000100;
      end
   end
endmodule

/* File: tb/vtcp_top_tb_top.sv */
// Self-checking bench of the voltage and temperature channel path
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module vtcp_top_tb_top;
   typedef struct {int k; logic [15:0] a; logic [31:0] d;} vtcp_row_t;
   logic             clk_in = 1'b0;
   logic             resetn_in = 1'b0;
   logic             reg_wr, reg_rd, stb, wave_ready;
   logic [15:0]      addr = 16'h0000;
   logic [31:0]      wdata = 32'h0, rdata;
   wire  [3:0]       sel;
   logic [3:0]       oload;
   logic [3:0][23:0] volt, third;
   logic [3:0][7:0]  oval;
   logic [23:0]      ra, rb, rc;
   logic [26:0]      wdat;
   logic             wval, irq_n, pin;
   int               error_cnt = 0, cmp_count = 0, n;
   vtcp_row_t        rows [25] = '{
      '{0, 16'hE618, 32'h10}, '{0, 16'hE708, 32'hF}, '{0, 16'hE50A, 32'h0},
      '{0, 16'hE502, 32'h0}, '{0, 16'hE710, 32'hFF}, '{1, 16'hE710, 32'h55},
      '{0, 16'hE710, 32'hFF}, '{1, 16'h1234, 32'hFFFFFFFF}, '{0, 16'h1234, 32'h0},
      '{1, 16'hE618, 32'h0}, '{0, 16'hE618, 32'h0}, '{1, 16'h4388, 32'h400000},
      '{0, 16'h4388, 32'h4000000}, '{1, 16'h4389, 32'hC00000}, '{0, 16'h4389, 32'hFC000000},
      '{1, 16'hE50A, 32'h20000}, '{2, 16'h0, 32'h0}, '{0, 16'hE530, 32'h180000},
      '{0, 16'hE531, 32'h100000}, '{0, 16'hE533, 32'hFFF00000}, '{0, 16'hE534, 32'hA0000},
      '{0, 16'hE502, 32'h20000}, '{1, 16'hE502, 32'h20000}, '{0, 16'hE502, 32'h0},
      '{0, 16'hE520, 32'h0}};
   always #25 clk_in = ~clk_in;
   vtcp_fe_model fe (.clk_in(clk_in), .resetn_in(resetn_in), .select_in(sel), .volt_out(volt),
      .third_out(third), .offset_load_out(oload), .offset_value_out(oval));
   // Short settle count keeps the temperature wait small
   vtcp_top #(.TEMP_SETTLE_CYC(50), .FIFO_DEPTH(4)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .sample_strobe_in(stb), .volt_adc_in(volt), .third_adc_in(third),
      .offset_load_in(oload), .offset_value_in(oval), .select_out_a(sel[0]),
      .select_out_b(sel[1]), .select_out_c(sel[2]), .select_out_n(sel[3]),
      .route_volt_to_a_out(ra), .route_volt_to_b_out(rb), .route_volt_to_c_out(rc),
      .wave_data_out(wdat), .wave_valid_out(wval), .wave_ready_in(wave_ready),
      .interrupt_0_n_out(irq_n), .shared_event_pin_out(pin));
   // ----------------------------------------------------------------
   // Bus, strobe and verdict helpers
   // ----------------------------------------------------------------
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_wr <= wr;
      reg_rd <= ~wr;
      addr   <= a;
      wdata  <= d;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      @(posedge clk_in);
      #1;
      `CHK("reg read", e, rdata)
   endtask
   task automatic strobe(input int gap);
      @(posedge clk_in);
      stb <= 1'b1;
      @(posedge clk_in);
      stb <= 1'b0;
      repeat (gap) @(posedge clk_in);
   endtask
   task automatic final_report();
      if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [23:0] rt(int c, int p);
      logic [23:0] v [3] = '{24'h180000, 24'h100000, 24'h300000};
      return v[(c == 1) ? (p + 1) % 3 : (c == 2) ? (p + 2) % 3 : p];
   endfunction
   initial begin
      repeat (6000) @(posedge clk_in);
      error_cnt++;
      final_report();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      stb = 1'b0;
      wave_ready = 1'b1;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      #1;
      `CHK("reset outs", 7'h7E, {sel, irq_n, pin, wval})
      foreach (rows[i]) begin
         if (rows[i].k == 2) strobe(12);
         else if (rows[i].k == 1) acc(1'b1, rows[i].a, rows[i].d);
         else rd_chk(rows[i].a, rows[i].d);
      end
      strobe(2);
      #1;
      `CHK("irq", 1'b0, irq_n)
      `CHK("pin early", 1'b1, pin)
      @(posedge clk_in);
      #1;
      `CHK("pin low", 1'b0, pin)
      repeat (199) @(posedge clk_in);
      #1;
      `CHK("pin end", 1'b0, pin)
      @(posedge clk_in);
      #1;
      `CHK("pin back", 1'b1, pin)
      rd_chk(16'hE530, 32'h00180000);
      acc(1'b1, 16'hE502, 32'h20000);
      @(posedge clk_in);
      #1;
      `CHK("irq clear", 1'b1, irq_n)
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, 16'hE618, 32'(c) * 32'h1500);
         strobe(1);
         #1;
         `CHK("route a", rt(c, 0), ra)
         `CHK("route b", rt(c, 1), rb)
         `CHK("route c", rt(c, 2), rc)
         repeat (8) @(posedge clk_in);
      end
      acc(1'b1, 16'hE708, 32'h0);
      #1;
      `CHK("select", 4'h0, sel)
      strobe(12);
      rd_chk(16'hE520, 32'h0);
      repeat (50) @(posedge clk_in);
      strobe(12);
      rd_chk(16'hE520, 32'h00FFF900);
      acc(1'b1, 16'h4380, 32'h400000);
      strobe(12);
      rd_chk(16'hE520, 32'h00FFF580);
      @(posedge clk_in);
      wave_ready <= 1'b0;
      strobe(20);
      #1;
      `CHK("fifo held", 1'b1, wval)
      @(posedge clk_in);
      wave_ready <= 1'b1;
      n = 0;
      repeat (20) begin
         #1;
         if (wval === 1'b1) begin
            `CHK("wave index", 3'(n), wdat[26:24])
            n++;
         end
         @(posedge clk_in);
      end
      `CHK("wave count", 4'h8, 4'(n))
      acc(1'b1, 16'hE618, 32'h10);
      repeat (3) strobe(12);
      acc(1'b0, 16'hE530, 32'h0);
      @(posedge clk_in);
      #1;
      `CHK("filtered", 1'b1, rdata > 32'h00100000 && rdata < 32'h00180000)
      resetn_in <= 1'b0;
      @(posedge clk_in);
      resetn_in <= 1'b1;
      #1;
      `CHK("reset again", 7'h7E, {sel, irq_n, pin, wval})
      final_report();
   end
endmodule
